// >>> hw/pfo_defs.svh
// constants for the port f/g override block
`ifndef PFO_DEFS_SVH
`define PFO_DEFS_SVH
`define PFO_ADDR_W            8
`define PFO_PORT_A_OUTPUT_LATCH_IO_ADDR     8'h1B
`define PFO_PORT_A_OUTPUT_LATCH_DATA_ADDR   8'h3B
`define PFO_PORT_A_OUTPUT_LATCH_RESET       8'h00
`define PFO_F_TDI_BIT         7
`define PFO_F_TDO_BIT         6
`define PFO_F_TMS_BIT         5
`define PFO_F_TCK_BIT         4
`define PFO_G_XTAL_OUT_BIT    4
`define PFO_G_XTAL_IN_BIT     3
`define PFO_G_ALE_BIT         2
`define PFO_G_RD_BIT          1
`define PFO_G_WR_BIT          0
`define PFO_IR_W              4
`define PFO_IR_RESET          4'hF
`define PFO_IR_CAPTURE        4'h1
`endif

// >>> hw/pfo_pkg.sv
// types for the port f/g override block
`default_nettype none
package pfo_pkg;
    typedef enum logic [3:0] {
        PFO_TLR  = 4'h0, PFO_RTI  = 4'h1, PFO_SDRS = 4'h2, PFO_CDR  = 4'h3,
        PFO_SDR  = 4'h4, PFO_E1DR = 4'h5, PFO_PDR  = 4'h6, PFO_E2DR = 4'h7,
        PFO_UDR  = 4'h8, PFO_SIRS = 4'h9, PFO_CIR  = 4'hA, PFO_SIR  = 4'hB,
        PFO_E1IR = 4'hC, PFO_PIR  = 4'hD, PFO_E2IR = 4'hE, PFO_UIR  = 4'hF
    } pfo_tap_state_type;
endpackage : pfo_pkg
`default_nettype wire

// >>> hw/pfo_tap.sv
// tap controller, clocked by core clock with test clock edge enables: rising for state and registers, falling for test-out
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defs.svh"
module pfo_tap
    import pfo_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic tck_i,
    input  wire logic tms_i,
    input  wire logic tdi_i,
    output logic      shift_ir_o,
    output logic      shift_dr_o,
    output logic      tdo_o
);
    pfo_tap_state_type state_r;
    pfo_tap_state_type state_nxt;
    logic                   tck_d_r;
    logic [`PFO_IR_W-1:0]   ir_r;
    logic                   bypass_r;
    logic                   tdo_r;
    wire                    tck_rise = tck_i & ~tck_d_r;
    wire                    tck_fall = ~tck_i & tck_d_r;

    // ------------------------------------------------
    // state transitions on tms
    // ------------------------------------------------
    always_comb begin
        case (state_r)
            PFO_TLR:  state_nxt = tms_i ? PFO_TLR  : PFO_RTI;
            PFO_RTI:  state_nxt = tms_i ? PFO_SDRS : PFO_RTI;
            PFO_SDRS: state_nxt = tms_i ? PFO_SIRS : PFO_CDR;
            PFO_CDR:  state_nxt = tms_i ? PFO_E1DR : PFO_SDR;
            PFO_SDR:  state_nxt = tms_i ? PFO_E1DR : PFO_SDR;
            PFO_E1DR: state_nxt = tms_i ? PFO_UDR  : PFO_PDR;
            PFO_PDR:  state_nxt = tms_i ? PFO_E2DR : PFO_PDR;
            PFO_E2DR: state_nxt = tms_i ? PFO_UDR  : PFO_SDR;
            PFO_UDR:  state_nxt = tms_i ? PFO_SDRS : PFO_RTI;
            PFO_SIRS: state_nxt = tms_i ? PFO_TLR  : PFO_CIR;
            PFO_CIR:  state_nxt = tms_i ? PFO_E1IR : PFO_SIR;
            PFO_SIR:  state_nxt = tms_i ? PFO_E1IR : PFO_SIR;
            PFO_E1IR: state_nxt = tms_i ? PFO_UIR  : PFO_PIR;
            PFO_PIR:  state_nxt = tms_i ? PFO_E2IR : PFO_PIR;
            PFO_E2IR: state_nxt = tms_i ? PFO_UIR  : PFO_SIR;
            PFO_UIR:  state_nxt = tms_i ? PFO_SDRS : PFO_RTI;
            default:  state_nxt = PFO_TLR;
        endcase
    end

    assign shift_ir_o = (state_r == PFO_SIR);
    assign shift_dr_o = (state_r == PFO_SDR);
    assign tdo_o      = tdo_r;

    // ------------------------------------------------
    // state, instruction and bypass registers
    // ------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tck_d_r  <= 1'b0;
            state_r  <= PFO_TLR;
            ir_r     <= `PFO_IR_RESET;
            bypass_r <= 1'b0;
            tdo_r    <= 1'b0;
        end else begin
            tck_d_r <= tck_i;
            if (tck_rise) begin
                state_r <= state_nxt;
                if (state_r == PFO_CIR) ir_r <= `PFO_IR_CAPTURE;
                if (state_r == PFO_SIR) ir_r <= {tdi_i, ir_r[`PFO_IR_W-1:1]};
                if (state_r == PFO_CDR) bypass_r <= 1'b0;
                if (state_r == PFO_SDR) bypass_r <= tdi_i;
            end
            if (tck_fall) begin
                tdo_r <= (state_r == PFO_SIR) ? ir_r[0] : bypass_r;
            end
        end
    end

    shift_onehot_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i) !(shift_ir_o && shift_dr_o))
        else $error("both shift states at once");
    state_hold_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i) !$past(tck_rise) |-> $stable(state_r))
        else $error("tap state moved without test clock");
    tdo_on_fall_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i) !$past(tck_fall) |-> $stable(tdo_o))
        else $error("test-out changed without test clock fall");
endmodule : pfo_tap
`default_nettype wire

// >>> hw/pfo_ovr_sel.sv
// per-pin override selection of one port
`timescale 1ns/1ps
`default_nettype none
module pfo_ovr_sel #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pullup_norm_i,
    input  wire logic [W-1:0] dir_norm_i,
    input  wire logic [W-1:0] value_norm_i,
    input  wire logic [W-1:0] inen_norm_i,
    input  wire logic [W-1:0] pullup_override_enable_i,
    input  wire logic [W-1:0] pullup_override_value_i,
    input  wire logic [W-1:0] direction_override_enable_i,
    input  wire logic [W-1:0] direction_override_value_i,
    input  wire logic [W-1:0] pin_value_override_enable_i,
    input  wire logic [W-1:0] pin_value_override_value_i,
    input  wire logic [W-1:0] input_enable_override_enable_i,
    input  wire logic [W-1:0] input_enable_override_value_i,
    output logic      [W-1:0] pullup_o,
    output logic      [W-1:0] dir_o,
    output logic      [W-1:0] value_o,
    output logic      [W-1:0] inen_o
);
    function automatic logic [W-1:0] pick(input logic [W-1:0] en, input logic [W-1:0] ov,
                                          input logic [W-1:0] nm);
        pick = (en & ov) | (~en & nm);
    endfunction : pick

    assign pullup_o = pick(pullup_override_enable_i, pullup_override_value_i,
                           pullup_norm_i);
    assign dir_o    = pick(direction_override_enable_i, direction_override_value_i,
                           dir_norm_i);
    assign value_o  = pick(pin_value_override_enable_i, pin_value_override_value_i,
                           value_norm_i);
    assign inen_o   = pick(input_enable_override_enable_i, input_enable_override_value_i,
                           inen_norm_i);
endmodule : pfo_ovr_sel
`default_nettype wire

// >>> hw/pfo_top.sv
// port f/g alternate-function override block with port a output latch
// ------------------------------------------------
// Contract
// - scan port on: pull-ups on test-in, mode, clock pins, even in reset; off on test-out
// - scan port on: four test pins lose direction, pull-up and digital input
// - scan port on: test-out pin driven only in shift-ir or shift-dr, else released
// - scan port on: test-out value is serial data from ir or data register
// - tap navigated by mode select, all test operation synchronous to test clock
// - no overrides on lower four adc port pins, except legacy mode forcing their direction to input
// - legacy mode: every adc port pin is input only, except test-out, driven in shift-ir or shift-dr while the scan port is on
// - legacy mode: five-pin port carries only alternate functions
// - timer clock select: bit 4 crystal output, pull-up and direction 0, input off
// - timer clock select: bit 3 crystal input, unusable as i/o
// - ext memory on: bits 2,1,0 outputs, no pull-up, drive latch, read, write
// - port a output latch at 0x1B / 0x3B, reset to zero
// ------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defs.svh"
module pfo_top
    import pfo_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [`PFO_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [7:0]             rdata_o,
    input  wire logic                   scan_port_enable_i,
    input  wire logic                   legacy_mode_i,
    input  wire logic                   async_timer_clock_select_i,
    input  wire logic                   ext_memory_enable_i,
    input  wire logic                   ale_i,
    input  wire logic                   rd_strobe_i,
    input  wire logic                   wr_strobe_i,
    input  wire logic [7:0]             f_pullup_norm_i,
    input  wire logic [7:0]             f_dir_norm_i,
    input  wire logic [7:0]             f_value_norm_i,
    input  wire logic [7:0]             f_inen_norm_i,
    input  wire logic [4:0]             g_pullup_norm_i,
    input  wire logic [4:0]             g_dir_norm_i,
    input  wire logic [4:0]             g_value_norm_i,
    input  wire logic [4:0]             g_inen_norm_i,
    input  wire logic [7:0]             f_pin_i,
    output logic      [7:0]             f_pullup_o,
    output logic      [7:0]             f_pin_o,
    output logic      [7:0]             f_pin_oe_o,
    output logic      [7:0]             f_inen_o,
    output logic      [7:0]             analog_pin_path_o,
    output logic      [4:0]             g_pullup_o,
    output logic      [4:0]             g_pin_o,
    output logic      [4:0]             g_pin_oe_o,
    output logic      [4:0]             g_inen_o,
    output logic                        timer_crystal_pin_one_en_o,
    output logic                        timer_crystal_pin_two_en_o,
    output logic      [7:0]             port_a_o
);
    logic [7:0] port_a_output_latch_r;
    logic [7:0] rdata_r;
    logic       shift_ir;
    logic       shift_dr;
    logic       tap_tdo;
    logic [7:0] f_dir;
    logic [4:0] g_dir;

    // ------------------------------------------------
    // register port
    // ------------------------------------------------
    wire hit_a = (addr_i == `PFO_PORT_A_OUTPUT_LATCH_IO_ADDR) || (addr_i == `PFO_PORT_A_OUTPUT_LATCH_DATA_ADDR);
    wire [7:0] rd_mux = hit_a ? port_a_output_latch_r : 8'h00;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_output_latch_r <= `PFO_PORT_A_OUTPUT_LATCH_RESET;
            rdata_r               <= 8'h00;
        end else begin
            if (wr_i && hit_a) port_a_output_latch_r <= wdata_i;
            rdata_r <= rd_i ? rd_mux : 8'h00;
        end
    end
    assign rdata_o  = rdata_r;
    assign port_a_o = port_a_output_latch_r;

    // ------------------------------------------------
    // tap controller
    // ------------------------------------------------
    pfo_tap u_tap (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .tck_i      (f_pin_i[`PFO_F_TCK_BIT] & scan_port_enable_i),
        .tms_i      (f_pin_i[`PFO_F_TMS_BIT]),
        .tdi_i      (f_pin_i[`PFO_F_TDI_BIT]),
        .shift_ir_o (shift_ir),
        .shift_dr_o (shift_dr),
        .tdo_o      (tap_tdo)
    );

    // ------------------------------------------------
    // port f override signals
    // ------------------------------------------------
    wire       jt      = scan_port_enable_i;
    wire [7:0] f_pullup_override_enable  = {jt, jt, jt, jt, 4'h0};
    wire [7:0] f_pullup_override_value  = {1'b1, 1'b0, 1'b1, 1'b1, 4'h0};
    wire [7:0] f_direction_override_enable  = {jt, jt, jt, jt, 4'h0};
    wire [7:0] f_direction_override_value  = {1'b0, shift_ir | shift_dr, 6'h00};
    wire [7:0] f_pin_value_override_enable  = {1'b0, jt, 6'h00};
    wire [7:0] f_pin_value_override_value  = {1'b0, tap_tdo, 6'h00};
    wire [7:0] f_input_enable_override_enable = {jt, jt, jt, jt, 4'h0};
    wire [7:0] f_input_enable_override_value = 8'h00;

    pfo_ovr_sel #(.W(8)) u_f_sel (
        .pullup_norm_i                  (f_pullup_norm_i),
        .dir_norm_i                     (legacy_mode_i ? 8'h00 : f_dir_norm_i),
        .value_norm_i                   (f_value_norm_i),
        .inen_norm_i                    (f_inen_norm_i),
        .pullup_override_enable_i       (f_pullup_override_enable),
        .pullup_override_value_i        (f_pullup_override_value),
        .direction_override_enable_i    (f_direction_override_enable),
        .direction_override_value_i     (f_direction_override_value),
        .pin_value_override_enable_i    (f_pin_value_override_enable),
        .pin_value_override_value_i     (f_pin_value_override_value),
        .input_enable_override_enable_i (f_input_enable_override_enable),
        .input_enable_override_value_i  (f_input_enable_override_value),
        .pullup_o                       (f_pullup_o),
        .dir_o                          (f_dir),
        .value_o                        (f_pin_o),
        .inen_o                         (f_inen_o)
    );
    assign f_pin_oe_o        = f_dir;
    assign analog_pin_path_o = f_pin_i;

    // ------------------------------------------------
    // port g override signals
    // ------------------------------------------------
    wire       ts      = async_timer_clock_select_i;
    wire       em      = ext_memory_enable_i | legacy_mode_i;
    wire [4:0] g_oe    = {ts, ts, em, em, em};
    wire [4:0] g_pullup_override_value  = 5'h00;
    wire [4:0] g_direction_override_value  = {2'b00, 3'b111};
    wire [4:0] g_pin_value_override_enable  = {2'b00, em, em, em};
    wire [4:0] g_pin_value_override_value  = {2'b00, ale_i, rd_strobe_i, wr_strobe_i};
    wire [4:0] g_input_enable_override_enable = {ts, ts, 3'b000};

    pfo_ovr_sel #(.W(5)) u_g_sel (
        .pullup_norm_i                  (legacy_mode_i ? 5'h00 : g_pullup_norm_i),
        .dir_norm_i                     (legacy_mode_i ? 5'h00 : g_dir_norm_i),
        .value_norm_i                   (g_value_norm_i),
        .inen_norm_i                    (legacy_mode_i ? 5'h00 : g_inen_norm_i),
        .pullup_override_enable_i       (g_oe),
        .pullup_override_value_i        (g_pullup_override_value),
        .direction_override_enable_i    (g_oe),
        .direction_override_value_i     (g_direction_override_value),
        .pin_value_override_enable_i    (g_pin_value_override_enable),
        .pin_value_override_value_i     (g_pin_value_override_value),
        .input_enable_override_enable_i (g_input_enable_override_enable),
        .input_enable_override_value_i  (5'h00),
        .pullup_o                       (g_pullup_o),
        .dir_o                          (g_dir),
        .value_o                        (g_pin_o),
        .inen_o                         (g_inen_o)
    );
    assign g_pin_oe_o                 = g_dir;
    assign timer_crystal_pin_one_en_o = ts;
    assign timer_crystal_pin_two_en_o = ts;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    scan_pullups_a: assert property (
        @(posedge core_clk_i) jt |-> (f_pullup_o[7:4] == 4'b1011))
        else $error("scan pull-ups wrong");
    scan_pins_a: assert property (
        @(posedge core_clk_i) jt |-> (f_inen_o[7:4] == 4'h0 && f_pin_oe_o[7] == 1'b0 &&
        f_pin_oe_o[5:4] == 2'b00))
        else $error("scan pins not isolated");
    tdo_drive_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        jt |-> (f_pin_oe_o[6] == (shift_ir | shift_dr)))
        else $error("test-out enable wrong");
    tdo_value_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        jt |-> (f_pin_o[6] == tap_tdo))
        else $error("test-out value wrong");
    low_f_plain_a: assert property (
        @(posedge core_clk_i) !legacy_mode_i |-> (f_pin_oe_o[3:0] == f_dir_norm_i[3:0] &&
        f_pullup_o[3:0] == f_pullup_norm_i[3:0]))
        else $error("low port f overridden");
    low_f_value_a: assert property (
        @(posedge core_clk_i) f_pin_o[3:0] == f_value_norm_i[3:0] &&
        f_inen_o[3:0] == f_inen_norm_i[3:0])
        else $error("low port f value overridden");
    legacy_in_a: assert property (
        @(posedge core_clk_i) (legacy_mode_i && !jt) |-> (f_pin_oe_o == 8'h00))
        else $error("legacy port f drives");
    legacy_g_a: assert property (
        @(posedge core_clk_i) legacy_mode_i |-> (g_pullup_o == 5'h00 &&
        g_pin_oe_o[2:0] == 3'b111 && g_pin_o[2:0] == {ale_i, rd_strobe_i, wr_strobe_i}))
        else $error("legacy port g not alternate");
    xtal_pins_a: assert property (
        @(posedge core_clk_i) ts |-> (g_pin_oe_o[4:3] == 2'b00 && g_pullup_o[4:3] == 2'b00 &&
        g_inen_o[4:3] == 2'b00))
        else $error("crystal pins not released");
    xmem_pins_a: assert property (
        @(posedge core_clk_i) (ext_memory_enable_i && !ts) |-> (g_pin_oe_o[2:0] == 3'b111 &&
        g_pin_o[2:0] == {ale_i, rd_strobe_i, wr_strobe_i}))
        else $error("strobes wrong");
    xmem_pull_a: assert property (
        @(posedge core_clk_i) ext_memory_enable_i |-> (g_pullup_o[2:0] == 3'b000))
        else $error("strobe pull-ups on");
    g_plain_a: assert property (
        @(posedge core_clk_i) (!ts && !em) |-> (g_pullup_o == g_pullup_norm_i &&
        g_pin_oe_o == g_dir_norm_i && g_pin_o == g_value_norm_i && g_inen_o == g_inen_norm_i))
        else $error("port g overridden while idle");
    latch_write_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_i && hit_a) |=> (port_a_o == $past(wdata_i)))
        else $error("latch write lost");
    read_data_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (rd_i && hit_a) |=> (rdata_o == $past(port_a_o)))
        else $error("latch read wrong");
    read_idle_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!rd_i || !hit_a) |=> (rdata_o == 8'h00))
        else $error("read data not cleared");
endmodule : pfo_top
`default_nettype wire

// >>> sim/pfo_tester.sv
// test port tester model driving the upper port f pins
`timescale 1ns/1ps
`default_nettype none
module pfo_tester (
    input  wire logic       core_clk_i,
    input  wire logic       tdo_oe_i,
    input  wire logic       tdo_val_i,
    input  wire logic       tdo_pu_i,
    output logic      [3:0] pins_o
);
    logic tck_r  = 1'b0;
    logic tms_r  = 1'b1;
    logic tdi_r  = 1'b0;
    logic last_r = 1'b0;
    logic pin6;
    // released test-out pin shows pull-up level or inverse of last level
    assign pin6   = tdo_oe_i ? tdo_val_i : (tdo_pu_i ? 1'b1 : ~last_r);
    assign pins_o = {tdi_r, pin6, tms_r, tck_r};
    always @(posedge core_clk_i) if (tdo_oe_i) last_r <= tdo_val_i;
    // one test clock period, clock high four core cycles and low nine, clock idle low
    task automatic tstep(input logic tms, input logic tdi);
        @(posedge core_clk_i);
        tms_r <= tms;
        tdi_r <= tdi;
        repeat (4) @(posedge core_clk_i);
        tck_r <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        tck_r <= 1'b0;
        repeat (4) @(posedge core_clk_i);
    endtask : tstep
endmodule : pfo_tester
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench of the port f/g override block
`timescale 1ns/1ps
`default_nettype none
`include "pfo_defs.svh"
module testbench;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic        wr_i = 1'b0, rd_i = 1'b0;
    logic        scan = 1'b1, legacy = 1'b0, async = 1'b0, ext = 1'b0;
    logic        ale = 1'b0, rds = 1'b0, wrs = 1'b0;
    logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, rdata_o, port_a_o, v, d;
    logic [7:0]  f_pu_n = 8'h00, f_dir_n = 8'h00, f_val_n = 8'h00, f_ien_n = 8'h00;
    logic [4:0]  g_pu_n = 5'h00, g_dir_n = 5'h00, g_val_n = 5'h00, g_ien_n = 5'h00;
    logic [3:0]  f_low = 4'h0, tpins;
    logic [7:0]  f_pu, f_pin, f_oe, f_ien, f_ana;
    logic [4:0]  g_pu, g_pin, g_oe, g_ien;
    logic        xt1, xt2;
    logic [15:0] lfsr_r = 16'h9C7C;
    logic [15:0] tmp;
    int          num_errors = 0;
    int          n_compared = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    pfo_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .scan_port_enable_i(scan), .legacy_mode_i(legacy),
        .async_timer_clock_select_i(async), .ext_memory_enable_i(ext),
        .ale_i(ale), .rd_strobe_i(rds), .wr_strobe_i(wrs),
        .f_pullup_norm_i(f_pu_n), .f_dir_norm_i(f_dir_n), .f_value_norm_i(f_val_n),
        .f_inen_norm_i(f_ien_n), .g_pullup_norm_i(g_pu_n), .g_dir_norm_i(g_dir_n),
        .g_value_norm_i(g_val_n), .g_inen_norm_i(g_ien_n), .f_pin_i({tpins, f_low}),
        .f_pullup_o(f_pu), .f_pin_o(f_pin), .f_pin_oe_o(f_oe), .f_inen_o(f_ien),
        .analog_pin_path_o(f_ana), .g_pullup_o(g_pu), .g_pin_o(g_pin),
        .g_pin_oe_o(g_oe), .g_inen_o(g_ien), .timer_crystal_pin_one_en_o(xt1),
        .timer_crystal_pin_two_en_o(xt2), .port_a_o(port_a_o));

    pfo_tester tester_u (.core_clk_i(core_clk_i), .tdo_oe_i(f_oe[6]),
        .tdo_val_i(f_pin[6]), .tdo_pu_i(f_pu[6]), .pins_o(tpins));

    function automatic logic [15:0] rv();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return lfsr_r;
    endfunction : rv

    function automatic logic [7:0] f_exp(input logic [7:0] nrm, input logic [3:0] ovr);
        return scan ? {ovr, nrm[3:0]} : nrm;
    endfunction : f_exp

    function automatic logic [7:0] g_exp(input logic [4:0] nrm, input logic [1:0] xt,
                                         input logic [2:0] mem);
        logic [4:0] n;
        n = legacy ? 5'h00 : nrm;
        return {3'h0, async ? xt : n[4:3], (ext | legacy) ? mem : n[2:0]};
    endfunction : g_exp

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] dat);
        @(posedge core_clk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, dat};
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] dat);
        @(posedge core_clk_i);
        {rd_i, addr_i} <= {1'b1, a};
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        dat = rdata_o;
    endtask : rd_reg

    task automatic drive_rand(input logic [3:0] modes);
        @(posedge core_clk_i);
        {scan, legacy, async, ext} <= modes;
        {f_pu_n, f_dir_n} <= rv();
        {f_val_n, f_ien_n} <= rv();
        {g_pu_n, g_dir_n, g_val_n, ale} <= rv();
        tmp = rv();
        {g_ien_n, rds, wrs, f_low} <= tmp[10:0];
    endtask : drive_rand

    task automatic check_pins(input logic sh);
        #1;
        chk(f_pu, f_exp(f_pu_n, 4'hB));
        chk(f_oe, f_exp(legacy ? 8'h00 : f_dir_n, {1'b0, sh, 2'b00}));
        chk(f_ien, f_exp(f_ien_n, 4'h0));
        chk(f_pin & 8'hBF, f_val_n & 8'hBF);
        chk(f_ana, {tpins, f_low});
        chk(8'(g_pu), g_exp(g_pu_n, 2'b00, 3'b000));
        chk(8'(g_oe), g_exp(g_dir_n, 2'b00, 3'b111));
        chk(8'(g_ien), g_exp(g_ien_n, 2'b00, legacy ? 3'b000 : g_ien_n[2:0]));
        chk(8'(g_pin), {3'h0, g_val_n[4:3], (ext | legacy) ? {ale, rds, wrs}
            : g_val_n[2:0]});
        chk({6'h00, xt1, xt2}, {6'h00, async, async});
    endtask : check_pins

    task automatic tdo_is(input logic b);
        check_pins(1'b1);
        chk({7'h00, f_pin[6]}, {7'h00, b});
    endtask : tdo_is

    initial begin
        #200us;
        num_errors++;
        $display("timeout");
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge core_clk_i);
        #1;
        chk(f_pu & 8'hF0, 8'hB0);
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk(port_a_o, `PFO_PORT_A_OUTPUT_LATCH_RESET);
        rd_reg(`PFO_PORT_A_OUTPUT_LATCH_IO_ADDR, d);
        chk(d, 8'h00);
        tmp = rv();
        v = tmp[7:0];
        wr_reg(`PFO_PORT_A_OUTPUT_LATCH_IO_ADDR, v);
        rd_reg(`PFO_PORT_A_OUTPUT_LATCH_DATA_ADDR, d);
        chk(d, v);
        @(posedge core_clk_i);
        #1;
        chk(rdata_o, 8'h00);
        wr_reg(8'h1C, ~v);
        rd_reg(8'h1C, d);
        chk(d, 8'h00);
        chk(port_a_o, v);
        $display("register test done");
        for (int i = 0; i < 40; i++) begin
            tmp = rv();
            drive_rand(i < 16 ? 4'(i) : tmp[3:0]);
            check_pins(1'b0);
        end
        $display("override test done");
        // norms held still from here while the test port runs
        drive_rand(4'h8);
        repeat (5) tester_u.tstep(1'b1, 1'b0);
        check_pins(1'b0);
        tester_u.tstep(1'b0, 1'b0);
        tester_u.tstep(1'b1, 1'b0);
        tester_u.tstep(1'b1, 1'b0);
        tester_u.tstep(1'b0, 1'b0);
        tester_u.tstep(1'b0, 1'b0);
        tdo_is(1'b1);
        for (int k = 0; k < 4; k++) begin
            tester_u.tstep(1'b0, 1'b1);
            tdo_is(k == 3);
        end
        tester_u.tstep(1'b1, 1'b0);
        check_pins(1'b0);
        tester_u.tstep(1'b1, 1'b0);
        tester_u.tstep(1'b1, 1'b0);
        tester_u.tstep(1'b0, 1'b0);
        tester_u.tstep(1'b0, 1'b1);
        tdo_is(1'b0);
        tester_u.tstep(1'b0, 1'b1);
        tdo_is(1'b1);
        tester_u.tstep(1'b1, 1'b0);
        check_pins(1'b0);
        $display("test port test done");
        tester_u.tstep(1'b0, 1'b0);
        tester_u.tstep(1'b1, 1'b0);
        tester_u.tstep(1'b0, 1'b1);
        check_pins(1'b1);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk(f_pu & 8'hF0, 8'hB0);
        chk(port_a_o, `PFO_PORT_A_OUTPUT_LATCH_RESET);
        check_pins(1'b0);
        @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        check_pins(1'b0);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
